/* File: iopb_map.svh */
`ifndef IOPB_MAP_SVH
`define IOPB_MAP_SVH
// Contract
// [RULE1] port and interrupt-flag ops need privilege within field
// [RULE2] privilege field changes only at level zero
// [RULE3] flag pop changes interrupt flag only if privileged
// [RULE4] protected and privileged skips map; else consult map (code: v86 consults map even when privileged, real mode never consults it)
// [RULE5] port p uses byte p/8 bit p%8
// [RULE6] any set bit across access width faults
// [RULE7] always fetch two consecutive map bytes
// [RULE8] map starts at task segment base offset
// [RULE9] bits beyond segment limit count as set
// [RULE10] base at or above limit means no map
// [RULE11] software keeps map base at most dfffh
// [RULE12] software adds all-ones byte after map
// [RULE13] accumulator width follows transfer size
// [RULE14] single transfer port from immediate or index
// [RULE15] strings: port index, source data, destination extra
// [RULE16] repeat steps memory index by direction flag
// [RULE17] port ops use port space only
// [RULE18] software marks mapped ports uncacheable
// [RULE19] port addresses are sixteen bits wide
// [RULE20] checks finish before any port cycle

// register offsets
`define IOPB_OFF_CTRL    8'h00
`define IOPB_OFF_TSS     8'h04
`define IOPB_OFF_STATUS  8'h08
`define IOPB_OFF_ACC     8'h0c
`define IOPB_OFF_SRC     8'h10
`define IOPB_OFF_DST     8'h14
`define IOPB_OFF_PORTIX  8'h18
// control, task segment and status fields
`define IOPB_F_CPL       1:0
`define IOPB_F_IO_PRIVILEGE_FIELD      3:2
`define IOPB_F_V86       4
`define IOPB_F_PROT      5
`define IOPB_F_IF        6
`define IOPB_F_DF        7
`define IOPB_F_MAPBASE   15:0
`define IOPB_F_LIMIT     31:16
`define IOPB_F_BUSY      0
`define IOPB_F_LASTGP    1
`define IOPB_F_GPCNT     31:16
// popped flags image
`define IOPB_FL_IO_PRIVILEGE_FIELD     13:12
`define IOPB_FL_IF       9
// map geometry
`define IOPB_MAP_BYTE    15:3
`define IOPB_MAP_BIT     2:0
`define IOPB_MASK_BYTE   4'h1
`define IOPB_MASK_WORD   4'h3
`define IOPB_MASK_DWORD  4'hf
`define IOPB_STEP_BYTE   32'h1
`define IOPB_STEP_WORD   32'h2
`define IOPB_STEP_DWORD  32'h4
`define IOPB_LEVEL0      2'h0
`define IOPB_RST_CTRL    8'h00
`define IOPB_RST_TSS     32'h0000_0000
`endif

/* File: iopb_pkg.sv */
package iopb_pkg;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_MAP  = 6'h02,
    S_IO   = 6'h04,
    S_MEM  = 6'h08,
    S_STEP = 6'h10,
    S_END  = 6'h20
  } iopb_state_t;
  typedef enum logic [3:0] {
    OP_IN   = 4'h0,
    OP_OUT  = 4'h1,
    OP_INS  = 4'h2,
    OP_STRING_PORT_OUTPUT_INSTR = 4'h3,
    OP_CLI  = 4'h4,
    OP_STI  = 4'h5,
    OP_FLAG_POP_INSTR = 4'h6,
    OP_INTERRUPT_RETURN_INSTR = 4'h7
  } iopb_op_t;
  typedef enum logic [1:0] {
    SZ_BYTE  = 2'h0,
    SZ_WORD  = 2'h1,
    SZ_DWORD = 2'h2
  } iopb_size_t;
endpackage

/* File: iopb_core.sv */
`include "iopb_map.svh"
module iopb_core import iopb_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  input  wire iopb_op_t    instr_op,
  input  wire iopb_size_t  instr_size,
  input  wire logic        instr_imm_sel,
  input  wire logic [15:0] instr_imm_port,
  input  wire logic        instr_rep,
  input  wire logic [15:0] instr_count,
  input  wire logic [31:0] instr_flags,
  output logic             instr_done,
  output logic             general_protection_fault,
  output logic             tss_rd_req,
  output logic [15:0]      tss_rd_addr,
  input  wire logic        tss_rd_ack,
  input  wire logic [15:0] tss_rd_data,
  output logic             io_req,
  output logic             io_space,
  output logic             io_write,
  output iopb_size_t       io_size,
  output logic [15:0]      io_addr,
  output logic [31:0]      io_wdata,
  input  wire logic        io_ack,
  input  wire logic [31:0] io_rdata,
  output logic             mem_req,
  output logic             mem_write,
  output logic             mem_extra_seg,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  iopb_state_t state_q, state_d;
  iopb_op_t    op_q;
  iopb_size_t  size_q;
  logic [7:0]  ctrl_q;
  logic [31:0] tss_q, acc_q, src_q, dst_q, data_q;
  logic [15:0] portix_q, port_q, cnt_q, gpcnt_q;
  logic        gp_q, done_q, lastgp_q, chk_ok_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire [1:0]  current_privilege_level       = ctrl_q[`IOPB_F_CPL];
  wire [1:0]  io_privilege_field      = ctrl_q[`IOPB_F_IO_PRIVILEGE_FIELD];
  wire [15:0] map_base  = tss_q[`IOPB_F_MAPBASE];
  wire [15:0] tss_limit = tss_q[`IOPB_F_LIMIT];
  wire        priv_ok   = current_privilege_level <= io_privilege_field;
  wire        fire      = instr_valid && instr_ready;
  wire        is_port   = (instr_op == OP_IN) || (instr_op == OP_OUT) ||
                          (instr_op == OP_INS) || (instr_op == OP_STRING_PORT_OUTPUT_INSTR);
  wire        is_str    = (instr_op == OP_INS) || (instr_op == OP_STRING_PORT_OUTPUT_INSTR);
  wire        is_ifop   = (instr_op == OP_CLI) || (instr_op == OP_STI);
  // [RULE4] map needed in protected mode when unprivileged or v86
  wire        need_map  = ctrl_q[`IOPB_F_PROT] && (ctrl_q[`IOPB_F_V86] || !priv_ok);
  // [RULE10] no map present
  wire        no_map    = map_base >= tss_limit;
  // [RULE1] privilege gate on interrupt flag ops
  wire        ifop_gp   = is_ifop && ctrl_q[`IOPB_F_PROT] && !priv_ok;
  // [RULE14] immediate or index register port
  wire [15:0] req_port  = (instr_imm_sel && !is_str) ? instr_imm_port : portix_q;
  // [RULE5] byte p/8 of the map
  wire [15:0] map_addr  = map_base + {3'h0, port_q[`IOPB_MAP_BYTE]};
  wire        hi_beyond = map_addr >= tss_limit;
  wire        lo_beyond = map_addr > tss_limit;
  wire [3:0]  sz_mask   = (size_q == SZ_BYTE) ? `IOPB_MASK_BYTE :
                          (size_q == SZ_WORD) ? `IOPB_MASK_WORD : `IOPB_MASK_DWORD;
  wire [15:0] bit_mask  = {12'h000, sz_mask} << port_q[`IOPB_MAP_BIT];
  // [RULE9] bytes past the limit read as set
  wire [15:0] map_eff   = {hi_beyond ? 8'hff : tss_rd_data[15:8],
                           lo_beyond ? 8'hff : tss_rd_data[7:0]};
  // [RULE6] any covered bit set faults
  wire        map_hit   = |(map_eff & bit_mask);
  wire [31:0] step_amt  = (size_q == SZ_BYTE) ? `IOPB_STEP_BYTE :
                          (size_q == SZ_WORD) ? `IOPB_STEP_WORD : `IOPB_STEP_DWORD;
  wire        df        = ctrl_q[`IOPB_F_DF];
  wire        out_dir   = (op_q == OP_OUT) || (op_q == OP_STRING_PORT_OUTPUT_INSTR);
  wire        step      = state_q == S_STEP;
  wire        last_item = cnt_q <= 16'h0001;
  wire        flag_pop_instr_fire = fire && (instr_op == OP_FLAG_POP_INSTR);
  wire        interrupt_return_instr_fire = fire && (instr_op == OP_INTERRUPT_RETURN_INSTR);
  wire        port_gp   = fire && is_port && need_map && no_map;
  wire        map_gp    = (state_q == S_MAP) && tss_rd_ack && map_hit;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire a_ctrl  = paddr == `IOPB_OFF_CTRL;
  wire a_tss   = paddr == `IOPB_OFF_TSS;
  wire a_stat  = paddr == `IOPB_OFF_STATUS;
  wire a_acc   = paddr == `IOPB_OFF_ACC;
  wire a_src   = paddr == `IOPB_OFF_SRC;
  wire a_dst   = paddr == `IOPB_OFF_DST;
  wire a_pix   = paddr == `IOPB_OFF_PORTIX;
  wire mapped  = a_ctrl || a_tss || a_stat || a_acc || a_src || a_dst || a_pix;
  wire busy    = state_q != S_IDLE;
  wire wr_err  = pwrite && busy && !a_stat;
  wire apb_acc = psel && penable;
  wire apb_wr  = apb_acc && pwrite && mapped && !wr_err;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && (!mapped || wr_err || (pwrite && a_stat));
  assign prdata  = a_ctrl ? {24'h000000, ctrl_q} :
                   a_tss  ? tss_q :
                   a_stat ? {gpcnt_q, 14'h0000, lastgp_q, busy} :
                   a_acc  ? acc_q :
                   a_src  ? src_q :
                   a_dst  ? dst_q :
                   a_pix  ? {16'h0000, portix_q} : 32'h0000_0000;

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign instr_ready              = state_q == S_IDLE;
  assign instr_done               = done_q;
  assign general_protection_fault = gp_q;
  // [RULE7] one fetch covers two map bytes
  assign tss_rd_req  = state_q == S_MAP;
  // [RULE8] address from map base field
  assign tss_rd_addr = map_addr;
  // [RULE20] port cycle only after checks pass
  assign io_req      = (state_q == S_IO) && chk_ok_q;
  // [RULE17] always the port space
  assign io_space    = 1'b1;
  assign io_write    = out_dir;
  assign io_size     = size_q;
  // [RULE19] sixteen-bit port address
  assign io_addr     = port_q;
  assign io_wdata    = data_q;
  // [RULE15] data/source for output, extra/destination for input
  assign mem_req       = state_q == S_MEM;
  assign mem_write     = op_q == OP_INS;
  assign mem_extra_seg = op_q == OP_INS;
  assign mem_addr      = (op_q == OP_INS) ? dst_q : src_q;
  assign mem_wdata     = data_q;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (fire && is_port && !port_gp) begin
          if (instr_rep && is_str && instr_count == 16'h0000) begin
            state_d = S_END;
          end else if (need_map) begin
            state_d = S_MAP;
          end else begin
            state_d = (instr_op == OP_STRING_PORT_OUTPUT_INSTR) ? S_MEM : S_IO;
          end
        end
      end
      S_MAP: begin
        if (tss_rd_ack) begin
          state_d = map_hit ? S_IDLE : ((op_q == OP_STRING_PORT_OUTPUT_INSTR) ? S_MEM : S_IO);
        end
      end
      S_IO: begin
        if (io_ack) begin
          state_d = (op_q == OP_INS) ? S_MEM : ((op_q == OP_STRING_PORT_OUTPUT_INSTR) ? S_STEP : S_END);
        end
      end
      S_MEM: begin
        if (mem_ack) begin
          state_d = (op_q == OP_STRING_PORT_OUTPUT_INSTR) ? S_IO : S_STEP;
        end
      end
      S_STEP: begin
        state_d = last_item ? S_END : ((op_q == OP_STRING_PORT_OUTPUT_INSTR) ? S_MEM : S_IO);
      end
      S_END: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= S_IDLE;
      op_q     <= OP_IN;
      size_q   <= SZ_BYTE;
      port_q   <= 16'h0000;
      cnt_q    <= 16'h0000;
      chk_ok_q <= 1'b0;
      gp_q     <= 1'b0;
      done_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      gp_q    <= port_gp || map_gp || (fire && ifop_gp);
      done_q  <= (state_q == S_END) || (fire && !is_port && !ifop_gp);
      if (fire) begin
        op_q     <= instr_op;
        size_q   <= instr_size;
        port_q   <= req_port;
        cnt_q    <= (instr_rep && is_str) ? instr_count : 16'h0001;
        chk_ok_q <= is_port && !need_map;
      end else if (state_q == S_MAP && tss_rd_ack) begin
        chk_ok_q <= !map_hit;
      end else if (state_q == S_END) begin
        chk_ok_q <= 1'b0;
      end
      if (step) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // architectural registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `IOPB_RST_CTRL;
      tss_q    <= `IOPB_RST_TSS;
      acc_q    <= 32'h0000_0000;
      src_q    <= 32'h0000_0000;
      dst_q    <= 32'h0000_0000;
      portix_q <= 16'h0000;
      data_q   <= 32'h0000_0000;
      gpcnt_q  <= 16'h0000;
      lastgp_q <= 1'b0;
    end else begin
      if (apb_wr && a_ctrl) begin
        ctrl_q[`IOPB_F_CPL]  <= pwdata[`IOPB_F_CPL];
        ctrl_q[`IOPB_F_V86]  <= pwdata[`IOPB_F_V86];
        ctrl_q[`IOPB_F_PROT] <= pwdata[`IOPB_F_PROT];
        ctrl_q[`IOPB_F_DF]   <= pwdata[`IOPB_F_DF];
      end
      if (apb_wr && a_tss) tss_q <= pwdata;
      if (apb_wr && a_acc) acc_q <= pwdata;
      if (apb_wr && a_src) src_q <= pwdata;
      if (apb_wr && a_dst) dst_q <= pwdata;
      if (apb_wr && a_pix) portix_q <= pwdata[15:0];
      // [RULE2] field loads only at level zero
      if ((flag_pop_instr_fire || interrupt_return_instr_fire) && current_privilege_level == `IOPB_LEVEL0) begin
        ctrl_q[`IOPB_F_IO_PRIVILEGE_FIELD] <= instr_flags[`IOPB_FL_IO_PRIVILEGE_FIELD];
      end
      // [RULE3] silent interrupt flag guard
      if ((flag_pop_instr_fire && priv_ok) || interrupt_return_instr_fire) begin
        ctrl_q[`IOPB_F_IF] <= instr_flags[`IOPB_FL_IF];
      end
      if (fire && is_ifop && !ifop_gp) begin
        ctrl_q[`IOPB_F_IF] <= instr_op == OP_STI;
      end
      if (fire && instr_op == OP_OUT) data_q <= acc_q;
      if (state_q == S_IO && io_ack && !out_dir) data_q <= io_rdata;
      if (state_q == S_MEM && mem_ack && op_q == OP_STRING_PORT_OUTPUT_INSTR) data_q <= mem_rdata;
      // [RULE13] accumulator slice by size
      if (state_q == S_IO && io_ack && op_q == OP_IN) begin
        case (size_q)
          SZ_BYTE: acc_q[7:0]  <= io_rdata[7:0];
          SZ_WORD: acc_q[15:0] <= io_rdata[15:0];
          default: acc_q       <= io_rdata;
        endcase
      end
      // [RULE16] index step by direction flag
      if (step && op_q == OP_STRING_PORT_OUTPUT_INSTR) src_q <= df ? src_q - step_amt : src_q + step_amt;
      if (step && op_q == OP_INS) dst_q <= df ? dst_q - step_amt : dst_q + step_amt;
      if (gp_q) begin
        gpcnt_q  <= gpcnt_q + 16'h0001;
        lastgp_q <= 1'b1;
      end else if (done_q) begin
        lastgp_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ifop_priv; fire && ifop_gp |=> general_protection_fault && $stable(ctrl_q[`IOPB_F_IF]); endproperty
  a_ifop_priv: assert property (p_ifop_priv) else $error("interrupt flag op not faulted"); // [RULE1]
  property p_io_privilege_field_keep; (flag_pop_instr_fire || interrupt_return_instr_fire) && current_privilege_level != `IOPB_LEVEL0 |=> $stable(io_privilege_field) && !general_protection_fault; endproperty
  a_io_privilege_field_keep: assert property (p_io_privilege_field_keep) else $error("privilege field changed off level zero"); // [RULE2]
  property p_if_keep; flag_pop_instr_fire && !priv_ok |=> $stable(ctrl_q[`IOPB_F_IF]) && !general_protection_fault; endproperty
  a_if_keep: assert property (p_if_keep) else $error("flag pop changed interrupt flag"); // [RULE3]
  property p_skip_map; fire && is_port && !need_map |=> !tss_rd_req; endproperty
  a_skip_map: assert property (p_skip_map) else $error("map fetched though privileged"); // [RULE4]
  property p_map_fault; map_gp |=> general_protection_fault ##1 !io_req; endproperty
  a_map_fault: assert property (p_map_fault) else $error("set map bit not faulted"); // [RULE6]
  property p_map_addr; tss_rd_req |-> tss_rd_addr == map_base + {3'h0, io_addr[`IOPB_MAP_BYTE]}; endproperty
  a_map_addr: assert property (p_map_addr) else $error("wrong map byte fetched"); // [RULE8]
  property p_no_map; port_gp |=> general_protection_fault && state_q == S_IDLE; endproperty
  a_no_map: assert property (p_no_map) else $error("missing map not faulted"); // [RULE10]
  property p_byte_in; state_q == S_IO && io_ack && op_q == OP_IN && size_q == SZ_BYTE |=> acc_q[31:8] == $past(acc_q[31:8]); endproperty
  a_byte_in: assert property (p_byte_in) else $error("byte input touched upper accumulator"); // [RULE13]
  property p_src_step; step && op_q == OP_STRING_PORT_OUTPUT_INSTR && !df |=> src_q == $past(src_q) + $past(step_amt); endproperty
  a_src_step: assert property (p_src_step) else $error("source index not incremented"); // [RULE16]
  property p_checked_io; io_req |-> chk_ok_q ##0 !tss_rd_req; endproperty
  a_checked_io: assert property (p_checked_io) else $error("port cycle before check"); // [RULE20]
endmodule

/* File: iopb_port_model.sv */
module iopb_port_model import iopb_pkg::*; #(
  parameter logic [31:0] RD_PAT  = 32'h5a3c_9600,
  parameter logic [31:0] MEM_PAT = 32'h1000_0000
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        slow,
  input  wire logic        tss_rd_req,
  input  wire logic [15:0] tss_rd_addr,
  output logic             tss_rd_ack,
  output logic [15:0]      tss_rd_data,
  input  wire logic        io_req,
  input  wire logic        io_space,
  input  wire logic [15:0] io_addr,
  input  wire logic [31:0] io_wdata,
  output logic             io_ack,
  output logic [31:0]      io_rdata,
  input  wire logic        mem_req,
  input  wire logic        mem_extra_seg,
  input  wire logic [31:0] mem_addr,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  output logic [7:0]       io_count,
  output logic [7:0]       tss_count,
  output logic [15:0]      last_io_addr,
  output logic [31:0]      last_io_wdata,
  output logic [15:0]      last_tss_addr,
  output logic [31:0]      last_mem_addr,
  output logic             last_mem_extra
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tss_mem [0:255];
  logic [3:0] wait_q;
  logic       busy;
  logic       fire;
  initial foreach (tss_mem[i]) tss_mem[i] = 8'h00;
  // ----------------------------------------
  // answer timing, prompt or slow
  // ----------------------------------------
  assign busy = (tss_rd_req | io_req | mem_req) & ~(tss_rd_ack | io_ack | mem_ack);
  assign fire = busy & (wait_q == (slow ? 4'h3 : 4'h0));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_q <= 4'h0;
      tss_rd_ack <= 1'b0;
      io_ack <= 1'b0;
      mem_ack <= 1'b0;
      tss_rd_data <= 16'h0000;
      io_rdata <= 32'h0000_0000;
      mem_rdata <= 32'h0000_0000;
      io_count <= 8'h00;
      tss_count <= 8'h00;
    end else begin
      wait_q <= (busy & ~fire) ? wait_q + 4'h1 : 4'h0;
      tss_rd_ack <= fire & tss_rd_req;
      io_ack <= fire & io_req;
      mem_ack <= fire & mem_req;
      // released data lines flip every cycle
      tss_rd_data <= (fire & tss_rd_req) ?
        {tss_mem[tss_rd_addr[7:0] + 8'h01], tss_mem[tss_rd_addr[7:0]]} : ~tss_rd_data;
      io_rdata <= (fire & io_req) ? RD_PAT ^ {io_addr, io_addr} : ~io_rdata;
      mem_rdata <= (fire & mem_req) ? MEM_PAT | mem_addr : ~mem_rdata;
      if (fire & tss_rd_req) begin
        tss_count <= tss_count + 8'h01;
        last_tss_addr <= tss_rd_addr;
      end
      if (fire & io_req & io_space) begin
        io_count <= io_count + 8'h01;
        last_io_addr <= io_addr;
        last_io_wdata <= io_wdata;
      end
      if (fire & mem_req) begin
        last_mem_addr <= mem_addr;
        last_mem_extra <= mem_extra_seg;
      end
    end
  end
endmodule

/* File: testbench.sv */
module testbench import iopb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] RD_PAT  = 32'h5a3c_9600;
  localparam logic [31:0] MEM_PAT = 32'h1000_0000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, re;
  logic [7:0]  paddr, io_count, tss_count, tc;
  logic        instr_valid, instr_ready, instr_imm_sel, instr_rep, instr_done, general_protection_fault;
  iopb_op_t    instr_op;
  iopb_size_t  instr_size;
  logic [15:0] instr_imm_port, instr_count, tss_rd_addr, tss_rd_data, io_addr, last_io_addr, last_tss_addr;
  logic        tss_rd_req, tss_rd_ack, io_req, io_space, io_ack, mem_req, mem_ack, mem_extra_seg, last_mem_extra;
  logic [31:0] pwdata, prdata, instr_flags, io_wdata, io_rdata, mem_addr, mem_rdata, last_io_wdata;
  logic [31:0] last_mem_addr, rv, exp_io, acc_exp;
  int          fails, compares;
  iopb_size_t  tsz [7] = '{SZ_DWORD, SZ_WORD, SZ_WORD, SZ_BYTE, SZ_BYTE, SZ_BYTE, SZ_BYTE};
  logic [15:0] tport [7] = '{16'h002a, 16'h0028, 16'h002f, 16'h0100, 16'h0208, 16'h0028, 16'h00ff};
  logic        tgp [7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

  iopb_core i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_op(instr_op), .instr_size(instr_size), .instr_imm_sel(instr_imm_sel),
    .instr_imm_port(instr_imm_port), .instr_rep(instr_rep), .instr_count(instr_count),
    .instr_flags(instr_flags), .instr_done(instr_done), .general_protection_fault(general_protection_fault),
    .tss_rd_req(tss_rd_req), .tss_rd_addr(tss_rd_addr), .tss_rd_ack(tss_rd_ack), .tss_rd_data(tss_rd_data),
    .io_req(io_req), .io_space(io_space), .io_write(), .io_size(), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_ack(io_ack), .io_rdata(io_rdata), .mem_req(mem_req), .mem_write(), .mem_extra_seg(mem_extra_seg),
    .mem_addr(mem_addr), .mem_wdata(), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  iopb_port_model #(.RD_PAT(RD_PAT), .MEM_PAT(MEM_PAT)) i_model (
    .pclk(pclk), .presetn(presetn), .slow(slow), .tss_rd_req(tss_rd_req), .tss_rd_addr(tss_rd_addr),
    .tss_rd_ack(tss_rd_ack), .tss_rd_data(tss_rd_data), .io_req(io_req), .io_space(io_space),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_ack(io_ack), .io_rdata(io_rdata), .mem_req(mem_req),
    .mem_extra_seg(mem_extra_seg), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .io_count(io_count), .tss_count(tss_count), .last_io_addr(last_io_addr), .last_io_wdata(last_io_wdata),
    .last_tss_addr(last_tss_addr), .last_mem_addr(last_mem_addr), .last_mem_extra(last_mem_extra));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic op(input iopb_op_t o, input iopb_size_t s, input logic [15:0] p, input logic [15:0] n,
                    input logic [31:0] fl, input logic gp);
    int k;
    @(posedge pclk);
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_size <= s;
    instr_imm_sel <= (p != 16'h0000);
    instr_imm_port <= p;
    instr_rep <= (o == OP_INS) || (o == OP_STRING_PORT_OUTPUT_INSTR);
    instr_count <= n;
    instr_flags <= fl;
    do @(posedge pclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (instr_done !== 1'b1 && general_protection_fault !== 1'b1 && k < 300);
    check("fault", general_protection_fault, gp);
    check("done", instr_done, !gp);
    if (!gp && o <= OP_STRING_PORT_OUTPUT_INSTR) exp_io = exp_io + n;
    check("port cycles", io_count, exp_io);
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_valid = 1'b0;
    instr_op = OP_IN;
    instr_size = SZ_BYTE;
    instr_imm_sel = 1'b0;
    instr_imm_port = 16'h0;
    instr_rep = 1'b0;
    instr_count = 16'h0;
    instr_flags = 32'h0;
    slow = 1'b0;
    exp_io = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    i_model.tss_mem[8'h40] = 8'hff;
    i_model.tss_mem[8'h25] = 8'h02;
    i_model.tss_mem[8'h26] = 8'h01;
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl reset", rv, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped err", re, 1'b1);
    apb(1'b1, 8'h00, 32'h20);
    op(OP_FLAG_POP_INSTR, SZ_BYTE, 16'h0, 16'h0, 32'h0000_1200, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl flag_pop_instr level0", rv, 32'h64);
    apb(1'b1, 8'h00, 32'h22);
    op(OP_FLAG_POP_INSTR, SZ_BYTE, 16'h0, 16'h0, 32'h0000_3000, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl flag_pop_instr level2", rv, 32'h66);
    op(OP_INTERRUPT_RETURN_INSTR, SZ_BYTE, 16'h0, 16'h0, 32'h0000_3000, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check("ctrl interrupt_return_instr level2", rv, 32'h26);
    op(OP_CLI, SZ_BYTE, 16'h0, 16'h0, 32'h0, 1'b1);
    op(OP_STI, SZ_BYTE, 16'h0, 16'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h0c, 32'h1122_3344);
    apb(1'b1, 8'h00, 32'h21);
    op(OP_OUT, SZ_WORD, 16'h0029, 16'h1, 32'h0, 1'b0);
    check("out port", last_io_addr, 32'h29);
    check("out data", last_io_wdata, 32'h1122_3344);
    check("map skipped", tss_count, 32'h0);
    apb(1'b1, 8'h04, 32'h0040_0020);
    apb(1'b1, 8'h00, 32'h22);
    for (int i = 0; i < 7; i++) begin
      op(OP_IN, tsz[i], tport[i], 16'h1, 32'h0, tgp[i]);
    end
    acc_exp = {RD_PAT[31:8] ^ 24'h002a_00, RD_PAT[7:0] ^ 8'hff};
    apb(1'b0, 8'h0c, 32'h0);
    check("acc slices", rv, acc_exp);
    check("map byte addr", last_tss_addr, 32'h3f);
    apb(1'b1, 8'h00, 32'h30);
    op(OP_IN, SZ_WORD, 16'h0028, 16'h1, 32'h0, 1'b1);
    apb(1'b1, 8'h04, 32'h0040_0040);
    apb(1'b1, 8'h00, 32'h22);
    tc = tss_count;
    op(OP_IN, SZ_BYTE, 16'h0028, 16'h1, 32'h0, 1'b1);
    check("no map fetch", tss_count, tc);
    apb(1'b1, 8'h04, 32'h0040_0020);
    apb(1'b1, 8'h18, 32'h38);
    apb(1'b1, 8'h10, 32'h100);
    slow <= 1'b1;
    op(OP_STRING_PORT_OUTPUT_INSTR, SZ_DWORD, 16'h0, 16'h3, 32'h0, 1'b0);
    apb(1'b0, 8'h10, 32'h0);
    check("src stepped", rv, 32'h10c);
    check("string port", last_io_addr, 32'h38);
    check("string data", last_io_wdata, MEM_PAT | 32'h108);
    apb(1'b1, 8'h00, 32'ha2);
    apb(1'b1, 8'h14, 32'h200);
    op(OP_INS, SZ_BYTE, 16'h0, 16'h2, 32'h0, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    check("dst stepped down", rv, 32'h1fe);
    check("dst addr", last_mem_addr, 32'h1ff);
    check("extra seg", last_mem_extra, 1'b1);
    apb(1'b1, 8'h00, 32'h02);
    tc = tss_count;
    op(OP_IN, SZ_WORD, 16'h0, 16'h1, 32'h0, 1'b0);
    check("real mode no map", tss_count, tc);
    check("index port", last_io_addr, 32'h38);
    apb(1'b0, 8'h0c, 32'h0);
    check("acc word", rv, {acc_exp[31:16], RD_PAT[15:0] ^ 16'h0038});
    print_verdict();
  end
endmodule
